// ===== dpp_pkg.sv
// Package: register map, field positions and reset values of the pointer/page block
package dpp_pkg;
   localparam logic [7:0] DPP_ADDR_PTR_A_LOW  = 8'h82;
   localparam logic [7:0] DPP_ADDR_PTR_A_HIGH = 8'h83;
   localparam logic [7:0] DPP_ADDR_PTR_B_LOW  = 8'h84;
   localparam logic [7:0] DPP_ADDR_PTR_B_HIGH = 8'h85;
   localparam logic [7:0] DPP_ADDR_CHOICE     = 8'h92;
   localparam logic [7:0] DPP_ADDR_PAGE       = 8'h93;
   localparam int         DPP_CHOICE_BIT      = 0;
   localparam logic [7:0] DPP_RESET_VAL       = 8'h00;
   localparam logic [15:0] DPP_XMAP_LO        = 16'hdf80;
   localparam logic [15:0] DPP_XMAP_HI        = 16'hdfff;

   // Special-function register access from the core
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dpp_sfr_req_t;

   // External-data address request from the core
   typedef struct packed {
      logic       valid;
      logic [15:0] addr;
   } dpp_xreq_t;
endpackage

// ===== dpp_byte_reg.sv
`timescale 1ns/10ps
// One byte register with address match, write enable and read data
module dpp_byte_reg
   import dpp_pkg::*;
#(
   parameter logic [7:0] ADDR = 8'h00
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Register access
   input  wire logic       wr,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   // Contents
   output logic      [7:0] q,
   output logic            hit
);
   assign hit = (addr == ADDR);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= DPP_RESET_VAL;
      end else if (wr && hit) begin
         q <= wdata;
      end
   end
endmodule // dpp_byte_reg

// ===== dpp_regs.sv
`timescale 1ns/10ps
// Data pointer, pointer choice and external page registers of the core
// Overview of operation
// R1: Two 16-bit pointers, high byte above low
// R2: Choice bit 0 selects pointer a or b
// R3: Pointer instructions use the chosen pointer
// R4: Four pointer bytes read/write, reset zero
// R5: Pointer bytes decode at 0x82 to 0x85
// R6: Page high byte, index register low byte
// R7: Port two latch never supplies high byte
// R8: Page at 0x93, choice at 0x92, reset zero
// R9: These registers only in special-function space
// R10: External range 0xDF80-0xDFFF excludes these registers
// R11: Unused choice bits ignore writes, read zero
module dpp_regs
   import dpp_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // Special-function register access
   input  wire dpp_sfr_req_t SFR_REQ,
   input  wire logic        SFR_RD,
   output logic       [7:0] SFR_RDATA,
   output logic             SFR_HIT,
   // Indirect external-data access
   input  wire logic  [7:0] INDIRECT_INDEX_REG,
   input  wire logic  [7:0] PORT_TWO_LATCH,
   output logic      [15:0] INDIRECT_ADDR,
   // Pointer use
   output logic      [15:0] ACTIVE_POINTER,
   output logic             POINTER_CHOICE,
   // External-data space decode
   input  wire dpp_xreq_t   XREQ,
   output logic             XMAP_SFR_HIT
);
   logic [1:0] rst_sync_r;
   logic       rst_b_int;
   logic [7:0] q [4];
   logic [3:0] hit;
   logic       choice_r;
   logic       choice_nxt;
   logic [7:0] page_r;
   logic [7:0] page_nxt;
   logic       wr_choice;
   logic       wr_page;
   logic [7:0] rd_mux;
   logic       rd_any;
   logic [15:0] pointer_a;
   logic [15:0] pointer_b;
   logic [15:0] ptr_sel;
   logic [15:0] ind_addr;
   logic       x_in_range;
   logic [7:0] x_sfr_addr;
   logic       x_internal;

   localparam logic [7:0] BYTE_ADDR [4] = '{DPP_ADDR_PTR_A_LOW, DPP_ADDR_PTR_A_HIGH,
                                           DPP_ADDR_PTR_B_LOW, DPP_ADDR_PTR_B_HIGH};

   // Reset release through two flops
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_b_int = rst_sync_r[1];

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_ptr_byte
         dpp_byte_reg #(.ADDR(BYTE_ADDR[i])) u_byte ( // R4 R5
            .clk   (CLK),
            .rst_b (rst_b_int),
            .wr    (SFR_REQ.wr),
            .addr  (SFR_REQ.addr),
            .wdata (SFR_REQ.wdata),
            .q     (q[i]),
            .hit   (hit[i])
         );
      end
   endgenerate

   assign pointer_a  = {q[1], q[0]}; // R1
   assign pointer_b  = {q[3], q[2]}; // R1
   assign wr_choice  = SFR_REQ.wr && (SFR_REQ.addr == DPP_ADDR_CHOICE);
   assign wr_page    = SFR_REQ.wr && (SFR_REQ.addr == DPP_ADDR_PAGE);
   assign choice_nxt = wr_choice ? SFR_REQ.wdata[DPP_CHOICE_BIT] : choice_r; // R2 R11
   assign page_nxt   = wr_page ? SFR_REQ.wdata : page_r; // R8

   always_ff @(posedge CLK or negedge rst_b_int) begin
      if (!rst_b_int) begin
         choice_r <= DPP_RESET_VAL[DPP_CHOICE_BIT];
         page_r   <= DPP_RESET_VAL;
      end else begin
         choice_r <= choice_nxt;
         page_r   <= page_nxt;
      end
   end

   // Read mux; unused choice bits read zero
   assign rd_mux = hit[0] ? q[0] :
                   hit[1] ? q[1] :
                   hit[2] ? q[2] :
                   hit[3] ? q[3] :
                   (SFR_REQ.addr == DPP_ADDR_CHOICE) ? {7'h00, choice_r} : // R11
                   (SFR_REQ.addr == DPP_ADDR_PAGE) ? page_r : 8'h00;
   assign rd_any = (|hit) || (SFR_REQ.addr == DPP_ADDR_CHOICE) ||
                   (SFR_REQ.addr == DPP_ADDR_PAGE);

   // Pointer selection for both code and external-data moves
   assign ptr_sel  = choice_nxt ? pointer_b : pointer_a; // R2 R3
   // Page alone gives the high byte; port two latch deliberately unused
   assign ind_addr = {page_nxt, INDIRECT_INDEX_REG}; // R6 R7

   // External-data window: core-internal registers never answer there
   assign x_in_range = XREQ.valid && (XREQ.addr >= DPP_XMAP_LO) && (XREQ.addr <= DPP_XMAP_HI);
   assign x_sfr_addr = {1'b1, XREQ.addr[6:0]};
   assign x_internal = (x_sfr_addr == DPP_ADDR_PTR_A_LOW) || (x_sfr_addr == DPP_ADDR_PTR_A_HIGH) ||
                       (x_sfr_addr == DPP_ADDR_PTR_B_LOW) || (x_sfr_addr == DPP_ADDR_PTR_B_HIGH) ||
                       (x_sfr_addr == DPP_ADDR_CHOICE) || (x_sfr_addr == DPP_ADDR_PAGE);

   always_ff @(posedge CLK or negedge rst_b_int) begin
      if (!rst_b_int) begin
         SFR_RDATA      <= 8'h00;
         SFR_HIT        <= 1'b0;
         ACTIVE_POINTER <= 16'h0000;
         POINTER_CHOICE <= 1'b0;
         INDIRECT_ADDR  <= 16'h0000;
         XMAP_SFR_HIT   <= 1'b0;
      end else begin
         SFR_RDATA      <= SFR_RD ? rd_mux : 8'h00;
         SFR_HIT        <= (SFR_RD || SFR_REQ.wr) && rd_any;
         ACTIVE_POINTER <= ptr_sel; // R3
         POINTER_CHOICE <= choice_nxt; // R2
         INDIRECT_ADDR  <= ind_addr; // R6
         XMAP_SFR_HIT   <= x_in_range && !x_internal; // R9 R10
      end
   end
endmodule // dpp_regs

// ===== dpp_regs_assertions.sv
`timescale 1ns/10ps
// Port checker of the pointer and page registers
module dpp_regs_assertions import dpp_pkg::*; (
   input wire logic CLK, RST_B, SFR_RD, SFR_HIT, POINTER_CHOICE, XMAP_SFR_HIT,
   input wire dpp_sfr_req_t SFR_REQ,
   input wire dpp_xreq_t XREQ,
   input wire logic [7:0] INDIRECT_INDEX_REG, SFR_RDATA,
   input wire logic [15:0] INDIRECT_ADDR, ACTIVE_POINTER
);
   logic [1:0] up_r;
   wire logic [7:0] ad = SFR_REQ.addr, wd = SFR_REQ.wdata;
   wire logic w = SFR_REQ.wr, on = up_r == 2'h3;
   wire logic own = ad inside {8'h82,8'h83,8'h84,8'h85,8'h92,8'h93};
   wire logic xo = XREQ.valid && XREQ.addr[15:7] == 9'h1bf
      && !({1'b1, XREQ.addr[6:0]} inside {8'h82,8'h83,8'h84,8'h85,8'h92,8'h93});
   // Counts out the reset synchroniser
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B) up_r <= 2'h0;
      else if (!on) up_r <= up_r + 2'h1;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   choice_wr_a: assert property (on && w && ad == 8'h92 |=> POINTER_CHOICE == $past(wd[0]))
      else $error("choice");
   page_wr_a: assert property (on && w && ad == 8'h93 |=> INDIRECT_ADDR[15:8] == $past(wd))
      else $error("page");
   index_low_a: assert property (on |-> INDIRECT_ADDR[7:0] == $past(INDIRECT_INDEX_REG))
      else $error("index");
   page_hold_a: assert property (on && !$past(w) |-> $stable(INDIRECT_ADDR[15:8]))
      else $error("page moved");
   ptr_hold_a: assert property (on && !$past(w) && !$past(w, 2) |-> $stable(ACTIVE_POINTER))
      else $error("pointer moved");
   map_hit_a: assert property (on && SFR_RD && !w |=> SFR_HIT == $past(own))
      else $error("hit");
   choice_rd_a: assert property (SFR_RD && !w && ad == 8'h92 |=> SFR_RDATA[7:1] == 7'h0)
      else $error("choice read");
   xmap_a: assert property (on |=> XMAP_SFR_HIT == $past(xo))
      else $error("window");
   cover property (on && w && ad == 8'h92 && wd[0]);
   cover property (xo);
   cover property (SFR_RD && !own);
endmodule // dpp_regs_assertions
bind dpp_regs dpp_regs_assertions i_chk (.*);

// ===== dpp_core_model.sv
`timescale 1ns/10ps
// Core side: index register, port latch and external probes
module dpp_core_model import dpp_pkg::*; (
   input wire logic clk,
   output dpp_xreq_t xreq = '0,
   output logic [7:0] idx = 8'h00, latch = 8'h00
);
   always @(negedge clk) begin
      idx <= 8'($urandom);
      latch <= 8'($urandom);
      xreq <= '{1'($urandom), {8'hdf, 8'($urandom)}};
   end
endmodule // dpp_core_model

// ===== dpp_regs_tb.sv
`timescale 1ns/10ps
// Self-checking bench of the pointer and page registers
module dpp_regs_tb import dpp_pkg::*;;
   logic c, rb, rd, h, pc, xh;
   dpp_sfr_req_t q;
   dpp_xreq_t x;
   logic [7:0] rv, ix, lt;
   logic [15:0] ia, ap;
   int fails, cmp_count, m [int];
   logic [7:0] ad [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'h93, 8'h86, 8'h91};
   dpp_regs i_dut (.CLK(c), .RST_B(rb), .SFR_REQ(q), .SFR_RD(rd), .SFR_RDATA(rv), .SFR_HIT(h),
      .INDIRECT_INDEX_REG(ix), .PORT_TWO_LATCH(lt), .INDIRECT_ADDR(ia), .ACTIVE_POINTER(ap),
      .POINTER_CHOICE(pc), .XREQ(x), .XMAP_SFR_HIT(xh));
   dpp_core_model i_core (.clk(c), .xreq(x), .idx(ix), .latch(lt));
   task automatic chk(string n, logic [15:0] s, e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      $display("%0d compares %0d fails", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Write one place, read another on the next cycle
   task automatic acc(logic [7:0] wa, d, ra);
      @(negedge c);
      q = '{1'b1, wa, d};
      if (m.exists(wa)) m[wa] = wa == 8'h92 ? d & 1 : d;
      @(negedge c);
      q = '{1'b0, ra, d};
      rd = 1'b1;
      @(negedge c);
      rd = 1'b0;
      chk("read", rv, m.exists(ra) ? m[ra] : 0);
      chk("hit", h, m.exists(ra));
      chk("xmap", xh, x.valid && x.addr >= 16'hdf80 && !(8'(x.addr) inside {8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'h93}));
      chk("choice", pc, m[8'h92]);
      chk("ptr", ap, m[8'h92] ? m[8'h85] << 8 | m[8'h84] : m[8'h83] << 8 | m[8'h82]);
      chk("ind", ia, m[8'h93] << 8 | ix);
   endtask
   initial begin
      c = 1'b0;
      forever #5 c = ~c;
   end
   initial begin
      fails = 0;
      cmp_count = 0;
      rb = 1'b0;
      rd = 1'b0;
      q = '0;
      void'($urandom(91));
      for (int i = 0; i < 6; i++) m[ad[i]] = 0;
      repeat (16) @(posedge c);
      @(negedge c);
      rb = 1'b1;
      repeat (2) @(negedge c);
      chk("reset ptr", ap, 16'h0000);
      chk("reset choice", pc, 0);
      foreach (ad[i]) acc(8'h91, 8'hff, ad[i]);
      repeat (99) acc(ad[$urandom % 8], 8'($urandom), ad[$urandom % 8]);
      finish_test;
   end
endmodule // dpp_regs_tb
